//--- src/uemsv_top.sv
// uncorrectable error status, mask and severity register bank with ahb-lite access
//
// How it works
// - mask bit 0 silences training errors
// - mask bit 4 silences data link protocol errors
// - mask bit 12 silences poisoned tlp events
// - mask bit 13 silences flow control protocol errors
// - mask bit 14 silences completion timeouts
// - mask bit 15 silences completer aborts
// - mask bit 16 silences unexpected completions
// - mask bit 17 silences receiver overflows
// - mask bit 18 silences malformed tlps
// - mask bit 19 silences ecrc errors
// - mask bit 20 silences unsupported requests
// - severity bit one means fatal, zero non-fatal
// - severity resets fatal for bits 0,4,13,17,18
// - status bit sets on event, write-one clears
`timescale 1ns/1ps
`default_nettype none
module uemsv_top
	import uemsv_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [31:0] err_event,
	output logic             log_capture,
	output logic      [31:0] log_error_vec,
	output logic             msg_fatal,
	output logic             msg_nonfatal,
	output logic             status_pending
);

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	wire logic [31:0] reg_addr;
	wire logic        reg_wr;
	wire logic [31:0] reg_wdata;
	wire logic [31:0] reg_rdata;

	uemsv_ahb_slave u_bus (
		.mclk      (mclk),
		.rst       (rst),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.reg_addr  (reg_addr),
		.reg_wr    (reg_wr),
		.reg_wdata (reg_wdata),
		.reg_rdata (reg_rdata)
	);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	wire logic sel_status;
	wire logic sel_mask;
	wire logic sel_sev;
	wire logic wr_status;
	wire logic wr_mask;
	wire logic wr_sev;

	assign sel_status = (reg_addr == UEMSV_STATUS_OFS);
	assign sel_mask   = (reg_addr == UEMSV_MASK_OFS);
	assign sel_sev    = (reg_addr == UEMSV_SEV_OFS);
	assign wr_status  = reg_wr && sel_status;
	assign wr_mask    = reg_wr && sel_mask;
	assign wr_sev     = reg_wr && sel_sev;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [31:0] status_reg;
	logic [31:0] status_next;
	logic [31:0] mask_reg;
	logic [31:0] mask_next;
	logic [31:0] sev_reg;
	logic [31:0] sev_next;
	wire  logic [31:0] event_vec;
	wire  logic [31:0] clear_vec;

	// events on reserved lanes are dropped here so they never reach status
	assign event_vec = err_event & UEMSV_IMPL_BITS;
	assign clear_vec = wr_status ? (reg_wdata & UEMSV_IMPL_BITS) : 32'h0000_0000;

	// an event in the clearing cycle survives: set is applied after clear
	assign status_next = (status_reg & ~clear_vec) | event_vec;
	assign mask_next   = wr_mask ? (reg_wdata & UEMSV_IMPL_BITS) : mask_reg;
	assign sev_next    = wr_sev ? (reg_wdata & UEMSV_IMPL_BITS) : sev_reg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			status_reg <= UEMSV_STATUS_RST;
			mask_reg   <= UEMSV_MASK_RST;
			sev_reg    <= UEMSV_SEV_RST;
		end else begin
			status_reg <= status_next;
			mask_reg   <= mask_next;
			sev_reg    <= sev_next;
		end
	end

	// unmapped addresses read as zero and ignore writes
	assign reg_rdata = sel_status ? status_reg :
	                   sel_mask   ? mask_reg   :
	                   sel_sev    ? sev_reg    : 32'h0000_0000;

	// ----------------------------------------------------------------
	// mask gating per error type
	// ----------------------------------------------------------------
	logic [31:0] block_vec;

	always_comb begin
		block_vec = 32'h0000_0000;
		block_vec[UEMSV_TRAIN_BIT]  = mask_reg[UEMSV_TRAIN_BIT];
		block_vec[UEMSV_DLP_BIT]    = mask_reg[UEMSV_DLP_BIT];
		block_vec[UEMSV_POISON_BIT] = mask_reg[UEMSV_POISON_BIT];
		block_vec[UEMSV_FCP_BIT]    = mask_reg[UEMSV_FCP_BIT];
		block_vec[UEMSV_CTO_BIT]    = mask_reg[UEMSV_CTO_BIT];
		block_vec[UEMSV_CA_BIT]     = mask_reg[UEMSV_CA_BIT];
		block_vec[UEMSV_UCPL_BIT]   = mask_reg[UEMSV_UCPL_BIT];
		block_vec[UEMSV_ROVF_BIT]   = mask_reg[UEMSV_ROVF_BIT];
		block_vec[UEMSV_MTLP_BIT]   = mask_reg[UEMSV_MTLP_BIT];
		block_vec[UEMSV_ECRC_BIT]   = mask_reg[UEMSV_ECRC_BIT];
		block_vec[UEMSV_UR_BIT]     = mask_reg[UEMSV_UR_BIT];
		block_vec[UEMSV_ACS_BIT]    = mask_reg[UEMSV_ACS_BIT];
	end

	wire logic [31:0] pass_vec;
	wire logic [31:0] fatal_vec;
	wire logic [31:0] nonfatal_vec;

	uemsv_err_route u_route (
		.event_vec    (event_vec),
		.block_vec    (block_vec),
		.sev_vec      (sev_reg),
		.pass_vec     (pass_vec),
		.fatal_vec    (fatal_vec),
		.nonfatal_vec (nonfatal_vec)
	);

	// ----------------------------------------------------------------
	// header log capture and message requests
	// ----------------------------------------------------------------
	logic        log_capture_reg;
	logic [31:0] log_error_vec_reg;
	logic        msg_fatal_reg;
	logic        msg_nonfatal_reg;
	logic        status_pending_reg;

	// severity is sampled in the detection cycle, so a severity write in
	// that same cycle does not affect the message already chosen
	always_ff @(posedge mclk) begin
		if (rst) begin
			log_capture_reg    <= 1'h0;
			log_error_vec_reg  <= 32'h0000_0000;
			msg_fatal_reg      <= 1'h0;
			msg_nonfatal_reg   <= 1'h0;
			status_pending_reg <= 1'h0;
		end else begin
			log_capture_reg    <= |pass_vec;
			log_error_vec_reg  <= pass_vec;
			msg_fatal_reg      <= |fatal_vec;
			msg_nonfatal_reg   <= |nonfatal_vec;
			status_pending_reg <= |status_next;
		end
	end

	assign log_capture    = log_capture_reg;
	assign log_error_vec  = log_error_vec_reg;
	assign msg_fatal      = msg_fatal_reg;
	assign msg_nonfatal   = msg_nonfatal_reg;
	assign status_pending = status_pending_reg;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence s_read_take;
		hsel && hready && (htrans == UEMSV_HTRANS_NONSEQ) && !hwrite;
	endsequence

	sequence s_read_answer;
		!hreadyout ##1 hreadyout;
	endsequence

	a_train_mask: assert property (
		err_event[UEMSV_TRAIN_BIT] && mask_reg[UEMSV_TRAIN_BIT]
		|=> !log_error_vec[UEMSV_TRAIN_BIT])
		else $error("masked training error reached log");
	a_dlp_mask: assert property (
		err_event[UEMSV_DLP_BIT] && mask_reg[UEMSV_DLP_BIT]
		|=> !log_error_vec[UEMSV_DLP_BIT])
		else $error("masked data link error reached log");
	a_poison_mask: assert property (
		err_event[UEMSV_POISON_BIT] && mask_reg[UEMSV_POISON_BIT]
		|=> !log_error_vec[UEMSV_POISON_BIT])
		else $error("masked poisoned tlp reached log");
	a_fcp_mask: assert property (
		err_event[UEMSV_FCP_BIT] && mask_reg[UEMSV_FCP_BIT]
		|=> !log_error_vec[UEMSV_FCP_BIT])
		else $error("masked flow control error reached log");
	a_cto_mask: assert property (
		err_event[UEMSV_CTO_BIT] && mask_reg[UEMSV_CTO_BIT]
		|=> !log_error_vec[UEMSV_CTO_BIT])
		else $error("masked completion timeout reached log");
	a_ca_mask: assert property (
		err_event[UEMSV_CA_BIT] && mask_reg[UEMSV_CA_BIT]
		|=> !log_error_vec[UEMSV_CA_BIT])
		else $error("masked completer abort reached log");
	a_ucpl_mask: assert property (
		err_event[UEMSV_UCPL_BIT] && mask_reg[UEMSV_UCPL_BIT]
		|=> !log_error_vec[UEMSV_UCPL_BIT])
		else $error("masked unexpected completion reached log");
	a_rovf_mask: assert property (
		err_event[UEMSV_ROVF_BIT] && mask_reg[UEMSV_ROVF_BIT]
		|=> !log_error_vec[UEMSV_ROVF_BIT])
		else $error("masked receiver overflow reached log");
	a_mtlp_mask: assert property (
		err_event[UEMSV_MTLP_BIT] && mask_reg[UEMSV_MTLP_BIT]
		|=> !log_error_vec[UEMSV_MTLP_BIT])
		else $error("masked malformed tlp reached log");
	a_ecrc_mask: assert property (
		err_event[UEMSV_ECRC_BIT] && mask_reg[UEMSV_ECRC_BIT]
		|=> !log_error_vec[UEMSV_ECRC_BIT])
		else $error("masked ecrc error reached log");
	a_ur_mask: assert property (
		err_event[UEMSV_UR_BIT] && mask_reg[UEMSV_UR_BIT]
		|=> !log_error_vec[UEMSV_UR_BIT])
		else $error("masked unsupported request reached log");

	a_all_masked_quiet: assert property (
		((event_vec & ~mask_reg) == 32'h0000_0000)
		|=> !log_capture && !msg_fatal && !msg_nonfatal)
		else $error("fully masked events still produced output");

	a_unmasked_logged: assert property (
		((event_vec & ~mask_reg) != 32'h0000_0000)
		|=> log_capture && (log_error_vec == $past(event_vec & ~mask_reg)))
		else $error("unmasked error not captured for header log");

	a_fatal_choice: assert property (
		((event_vec & ~mask_reg & sev_reg) != 32'h0000_0000) |=> msg_fatal)
		else $error("fatal class error gave no fatal message");

	a_nonfatal_choice: assert property (
		((event_vec & ~mask_reg & ~sev_reg) == 32'h0000_0000) |=> !msg_nonfatal)
		else $error("non-fatal message without non-fatal error");

	a_status_set: assert property (
		(event_vec != 32'h0000_0000)
		|=> ((status_reg & $past(event_vec)) == $past(event_vec)) && status_pending)
		else $error("status bit missed an event");

	a_status_clear: assert property (
		wr_status && (event_vec == 32'h0000_0000)
		|=> ((status_reg & $past(reg_wdata)) == 32'h0000_0000))
		else $error("write one did not clear status");

	a_reserved_zero: assert property (
		$past(reg_wr) |-> (((mask_reg | sev_reg | status_reg) & ~UEMSV_IMPL_BITS) == 32'h0000_0000))
		else $error("reserved register bit became set");

	a_reset_values: assert property (
		$past(rst) |-> (sev_reg == UEMSV_SEV_RST) && (mask_reg == UEMSV_MASK_RST))
		else $error("severity or mask reset value wrong");

	a_read_wait: assert property (
		s_read_take |=> s_read_answer)
		else $error("read answer not after exactly one wait cycle");

	// ----------------------------------------------------------------
	// register path checks
	// ----------------------------------------------------------------
	// these key off the bus pins rather than the internal write strobe,
	// so a broken address capture in the front end is caught as well
	sequence s_mask_write;
		hsel && hready && (htrans == UEMSV_HTRANS_NONSEQ) && hwrite
		&& (haddr == UEMSV_MASK_OFS) ##1 hreadyout;
	endsequence

	sequence s_sev_write;
		hsel && hready && (htrans == UEMSV_HTRANS_NONSEQ) && hwrite
		&& (haddr == UEMSV_SEV_OFS) ##1 hreadyout;
	endsequence

	sequence s_sev_read;
		hsel && hready && (htrans == UEMSV_HTRANS_NONSEQ) && !hwrite
		&& (haddr == UEMSV_SEV_OFS) ##1 !hreadyout;
	endsequence

	a_mask_write: assert property (
		s_mask_write |=> (mask_reg == ($past(hwdata) & UEMSV_IMPL_BITS)))
		else $error("mask write did not land as implemented bits");
	a_sev_write: assert property (
		s_sev_write |=> (sev_reg == ($past(hwdata) & UEMSV_IMPL_BITS)))
		else $error("severity write did not land as implemented bits");
	a_sev_readback: assert property (
		s_sev_read |=> (hrdata == $past(sev_reg)))
		else $error("severity read returned wrong value");
	a_read_rsvd: assert property (
		$rose(hreadyout) |-> ((hrdata & ~UEMSV_IMPL_BITS) == 32'h0000_0000))
		else $error("read data carried a reserved bit");

	// a register may only move on its own write, or on an event for status
	a_mask_keep: assert property (
		!wr_mask |=> $stable(mask_reg))
		else $error("mask changed without a mask write");
	a_sev_keep: assert property (
		!wr_sev |=> $stable(sev_reg))
		else $error("severity changed without a severity write");
	a_status_keep: assert property (
		!wr_status |=> (status_reg == ($past(status_reg) | $past(event_vec))))
		else $error("status changed other than by an event");

	// ----------------------------------------------------------------
	// message and log checks
	// ----------------------------------------------------------------
	a_acs_mask: assert property (
		err_event[UEMSV_ACS_BIT] && mask_reg[UEMSV_ACS_BIT]
		|=> !log_error_vec[UEMSV_ACS_BIT])
		else $error("masked acs violation reached log");
	a_nonfatal_sent: assert property (
		((event_vec & ~mask_reg & ~sev_reg) != 32'h0000_0000) |=> msg_nonfatal)
		else $error("non-fatal class error gave no non-fatal message");
	a_fatal_only: assert property (
		((event_vec & ~mask_reg & sev_reg) == 32'h0000_0000) |=> !msg_fatal)
		else $error("fatal message without fatal error");
	a_log_idle: assert property (
		!log_capture |-> (log_error_vec == 32'h0000_0000))
		else $error("log vector set without a capture");

endmodule
`default_nettype wire

//--- src/uemsv_pkg.sv
// constants shared by the uncorrectable error mask and severity register bank
package uemsv_pkg;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] UEMSV_STATUS_OFS = 32'h0000_0104;
	localparam logic [31:0] UEMSV_MASK_OFS   = 32'h0000_0108;
	localparam logic [31:0] UEMSV_SEV_OFS    = 32'h0000_010C;

	// ----------------------------------------------------------------
	// error type bit positions, common to status, mask and severity
	// ----------------------------------------------------------------
	localparam int UEMSV_TRAIN_BIT  = 0;
	localparam int UEMSV_DLP_BIT    = 4;
	localparam int UEMSV_POISON_BIT = 12;
	localparam int UEMSV_FCP_BIT    = 13;
	localparam int UEMSV_CTO_BIT    = 14;
	localparam int UEMSV_CA_BIT     = 15;
	localparam int UEMSV_UCPL_BIT   = 16;
	localparam int UEMSV_ROVF_BIT   = 17;
	localparam int UEMSV_MTLP_BIT   = 18;
	localparam int UEMSV_ECRC_BIT   = 19;
	localparam int UEMSV_UR_BIT     = 20;
	localparam int UEMSV_ACS_BIT    = 21;

	// implemented bits; all others are reserved and read as zero
	localparam logic [31:0] UEMSV_IMPL_BITS  = 32'h003F_F011;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] UEMSV_STATUS_RST = 32'h0000_0000;
	localparam logic [31:0] UEMSV_MASK_RST   = 32'h0000_0000;
	localparam logic [31:0] UEMSV_SEV_RST    = 32'h0006_2011;
	localparam logic [31:0] UEMSV_RDATA_RST  = 32'h0000_0000;

	// ----------------------------------------------------------------
	// bus encodings and slave states
	// ----------------------------------------------------------------
	localparam logic [1:0]  UEMSV_HTRANS_NONSEQ = 2'h2;
	localparam logic        UEMSV_HRESP_OKAY    = 1'h0;

	typedef enum logic [1:0] {
		UEMSV_BUS_IDLE,
		UEMSV_BUS_WRITE,
		UEMSV_BUS_READ
	} uemsv_bus_state_type;

endpackage

//--- src/uemsv_ahb_slave.sv
// ahb-lite slave front end: zero-wait writes, one-wait registered reads
`timescale 1ns/1ps
`default_nettype none
module uemsv_ahb_slave
	import uemsv_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] reg_addr,
	output logic             reg_wr,
	output logic      [31:0] reg_wdata,
	input  wire logic [31:0] reg_rdata
);

	// ----------------------------------------------------------------
	// address phase capture
	// ----------------------------------------------------------------
	uemsv_bus_state_type state_reg;
	logic        [31:0] addr_reg;
	logic        [31:0] hrdata_reg;
	logic               hreadyout_reg;
	wire logic          take;

	// only word transfers are expected; any hsize except 3'h7 is accepted, and hsize 3'h7 transfers are ignored
	assign take = hsel && hready && (htrans == UEMSV_HTRANS_NONSEQ) && (hsize != 3'h7);

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg     <= UEMSV_BUS_IDLE;
			addr_reg      <= 32'h0000_0000;
			hrdata_reg    <= UEMSV_RDATA_RST;
			hreadyout_reg <= 1'h1;
		end else if (state_reg == UEMSV_BUS_READ) begin
			hrdata_reg    <= reg_rdata;
			hreadyout_reg <= 1'h1;
			state_reg     <= UEMSV_BUS_IDLE;
		end else if (take) begin
			addr_reg      <= haddr;
			hreadyout_reg <= hwrite;
			state_reg     <= hwrite ? UEMSV_BUS_WRITE : UEMSV_BUS_READ;
		end else begin
			state_reg     <= UEMSV_BUS_IDLE;
		end
	end

	// write commits at the edge that ends the data phase
	assign reg_wr    = (state_reg == UEMSV_BUS_WRITE);
	assign reg_addr  = addr_reg;
	assign reg_wdata = hwdata;
	assign hrdata    = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp     = UEMSV_HRESP_OKAY;

endmodule
`default_nettype wire

//--- src/uemsv_err_route.sv
// per error type gating of events by mask and split by severity
`timescale 1ns/1ps
`default_nettype none
module uemsv_err_route
	import uemsv_pkg::*;
(
	input  wire logic [31:0] event_vec,
	input  wire logic [31:0] block_vec,
	input  wire logic [31:0] sev_vec,
	output logic      [31:0] pass_vec,
	output logic      [31:0] fatal_vec,
	output logic      [31:0] nonfatal_vec
);

	// ----------------------------------------------------------------
	// one lane per error type; reserved lanes never pass
	// ----------------------------------------------------------------
	for (genvar b = 0; b < 32; b++) begin : g_lane
		assign pass_vec[b]     = event_vec[b] && !block_vec[b] && UEMSV_IMPL_BITS[b];
		assign fatal_vec[b]    = pass_vec[b] && sev_vec[b];
		assign nonfatal_vec[b] = pass_vec[b] && !sev_vec[b];
	end

endmodule
`default_nettype wire

//--- test/uemsv_rc_model.sv
// root complex stand-in: counts error messages and accumulates captured error types
`timescale 1ns/1ps
`default_nettype none
module uemsv_rc_model (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        msg_fatal,
	input  wire logic        msg_nonfatal,
	input  wire logic        log_capture,
	input  wire logic [31:0] log_error_vec,
	output logic      [15:0] n_fatal,
	output logic      [15:0] n_nonfatal,
	output logic      [31:0] seen_vec
);
	// ----------------------------------------------------------------
	// message intake
	// ----------------------------------------------------------------
	// each pulse is one message; a stretched pulse would count twice, as a real receiver would
	always_ff @(posedge mclk) begin
		if (rst) begin
			n_fatal    <= 16'h0000;
			n_nonfatal <= 16'h0000;
			seen_vec   <= 32'h0000_0000;
		end else begin
			n_fatal    <= n_fatal + 16'(msg_fatal);
			n_nonfatal <= n_nonfatal + 16'(msg_nonfatal);
			if (log_capture) begin
				seen_vec <= seen_vec | log_error_vec;
			end
		end
	end
endmodule
`default_nettype wire

//--- test/tb_uemsv_top.sv
// self-checking bench for the uncorrectable error mask and severity bank
`timescale 1ns/1ps
`default_nettype none
module tb_uemsv_top;
	import uemsv_pkg::*;
	logic        mclk      = 1'b0;
	logic        rst       = 1'b1;
	logic        hsel      = 1'b0;
	logic [31:0] haddr     = 32'h0000_0000;
	logic [1:0]  htrans    = 2'h0;
	logic        hwrite    = 1'b0;
	logic [2:0]  hsize     = 3'h2;
	logic [31:0] hwdata    = 32'h0000_0000;
	logic [31:0] err_event = 32'h0000_0000;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        log_capture;
	logic [31:0] log_error_vec;
	logic        msg_fatal;
	logic        msg_nonfatal;
	logic        status_pending;
	logic [15:0] rc_fatal;
	logic [15:0] rc_nonfatal;
	logic [31:0] rc_seen;
	logic [31:0] mask_m    = 32'h0000_0000;
	logic [31:0] sev_m     = 32'h0006_2011;
	logic [31:0] status_m  = 32'h0000_0000;
	logic [31:0] seen_m    = 32'h0000_0000;
	int          exp_fat   = 0;
	int          exp_nf    = 0;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          bits[12]  = '{0, 4, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21};

	always #50 mclk = ~mclk;

	uemsv_top i_dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .err_event(err_event),
		.log_capture(log_capture), .log_error_vec(log_error_vec), .msg_fatal(msg_fatal),
		.msg_nonfatal(msg_nonfatal), .status_pending(status_pending));

	uemsv_rc_model i_rc (.mclk(mclk), .rst(rst), .msg_fatal(msg_fatal),
		.msg_nonfatal(msg_nonfatal), .log_capture(log_capture),
		.log_error_vec(log_error_vec), .n_fatal(rc_fatal), .n_nonfatal(rc_nonfatal),
		.seen_vec(rc_seen));

	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim;
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// ahb-lite master
	// ----------------------------------------------------------------
	// outputs are registered, so the level seen at the falling edge is the one sampled next
	task automatic wait_ready(output logic [31:0] d);
		int k;
		k = 0;
		@(negedge mclk);
		while (hreadyout !== 1'b1 && k < 50) begin
			k++;
			@(negedge mclk);
		end
		check("hready_wait", 32'(k < 50), 32'h1);
		d = hrdata;
		@(posedge mclk);
	endtask

	task automatic bus(input logic is_wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		logic [31:0] dummy;
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= is_wr;
		htrans <= UEMSV_HTRANS_NONSEQ;
		hsize  <= 3'h2;
		wait_ready(dummy);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready(rd);
		check("hresp", 32'(hresp), 32'h0);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask

	task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] v;
		bus(1'b0, a, 32'h0000_0000, v);
		check(name, v, exp);
	endtask

	task automatic reset_reads;
		rd_chk("status_rst", UEMSV_STATUS_OFS, 32'h0000_0000);
		rd_chk("mask_rst", UEMSV_MASK_OFS, 32'h0000_0000);
		// fatal at reset: bits 0, 4, 13, 17, 18
		rd_chk("sev_rst", UEMSV_SEV_OFS, 32'h0006_2011);
	endtask

	// ----------------------------------------------------------------
	// error events
	// ----------------------------------------------------------------
	task automatic fire(input logic [31:0] v);
		logic [31:0] p;
		p = v & 32'h003F_F011 & ~mask_m;
		err_event <= v;
		@(posedge mclk);
		err_event <= 32'h0000_0000;
		status_m = status_m | (v & 32'h003F_F011);
		seen_m = seen_m | p;
		exp_fat += int'(|(p & sev_m));
		exp_nf += int'(|(p & ~sev_m));
		@(negedge mclk);
		check("log_capture", 32'(log_capture), 32'(|p));
		check("log_error_vec", log_error_vec, p);
		check("msg_fatal", 32'(msg_fatal), 32'(|(p & sev_m)));
		check("msg_nonfatal", 32'(msg_nonfatal), 32'(|(p & ~sev_m)));
		check("status_pending", 32'(status_pending), 32'(status_m != 0));
		@(negedge mclk);
		check("pulse_end", 32'({log_capture, msg_fatal, msg_nonfatal}), 32'h0);
		@(posedge mclk);
	endtask

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] bm;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		reset_reads();
		wr(UEMSV_MASK_OFS, 32'hFFFF_FFFF);
		rd_chk("mask_rsvd", UEMSV_MASK_OFS, 32'h003F_F011);
		wr(UEMSV_SEV_OFS, 32'hFFFF_FFFF);
		rd_chk("sev_rsvd", UEMSV_SEV_OFS, 32'h003F_F011);
		wr(32'h0000_0100, 32'hFFFF_FFFF);
		rd_chk("unmapped", 32'h0000_0100, 32'h0000_0000);
		rd_chk("mask_kept", UEMSV_MASK_OFS, 32'h003F_F011);
		// a second reset in mid-run must restore every reset value
		rst <= 1'b1;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		reset_reads();
		foreach (bits[i]) begin
			bm = 32'h1 << bits[i];
			for (int s = 1; s >= 0; s--) begin
				sev_m = (s == 1) ? (32'h0006_2011 ^ bm) : 32'h0006_2011;
				wr(UEMSV_SEV_OFS, sev_m);
				fire(bm);
			end
			mask_m = bm;
			wr(UEMSV_MASK_OFS, mask_m);
			fire(bm);
			rd_chk("status_set", UEMSV_STATUS_OFS, bm);
			wr(UEMSV_STATUS_OFS, bm);
			status_m = 32'h0000_0000;
			rd_chk("status_clr", UEMSV_STATUS_OFS, 32'h0000_0000);
			mask_m = 32'h0000_0000;
			wr(UEMSV_MASK_OFS, mask_m);
		end
		// every type at once, with the middle group masked and reserved lines driven
		mask_m = 32'h0000_F000;
		wr(UEMSV_MASK_OFS, mask_m);
		fire(32'hFFFF_FFFF);
		wr(UEMSV_STATUS_OFS, 32'hFFC0_0011);
		status_m = status_m & ~32'h0000_0011;
		rd_chk("status_part", UEMSV_STATUS_OFS, status_m);
		check("rc_fatal", 32'(rc_fatal), 32'(exp_fat));
		check("rc_nonfatal", 32'(rc_nonfatal), 32'(exp_nf));
		check("rc_seen", rc_seen, seen_m);
		end_sim();
	end

	// the sequence needs well under two thousand cycles
	initial begin
		repeat (5000) @(posedge mclk);
		n_mismatch++;
		end_sim();
	end
endmodule
`default_nettype wire
